// ---- hdl/hbc_pkg.sv ----
package hbc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// host bus timing, times in ns
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETUP_NS = 25;
	localparam int STROBE_NS = 100;
	localparam int HOLD_NS = 25;
	// least times round up, never below one cycle
	localparam int SETUP_CYC_I = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC_I = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SETUP_CYC = 8'((SETUP_CYC_I < 1) ? 1 : SETUP_CYC_I);
	localparam logic [7:0] STROBE_CYC = 8'((STROBE_CYC_I < 1) ? 1 : STROBE_CYC_I);
	localparam logic [7:0] HOLD_CYC = 8'((HOLD_CYC_I < 1) ? 1 : HOLD_CYC_I);

	////////////////////////////////////////////////////////////////////////////
	// device register addresses on the 8-bit host bus
	localparam logic [3:0] DEV_COMMAND = 4'h2;
	localparam logic [3:0] DEV_LINE_SET_LOW = 4'h6;
	localparam logic [3:0] DEV_LINE_SET_HIGH = 4'h7;
	localparam logic [3:0] DEV_LINES_DONE_LOW = 4'h8;
	localparam logic [3:0] DEV_LINES_DONE_HIGH = 4'h9;
	localparam logic [3:0] DEV_TABLE_BUFFER = 4'ha;
	localparam logic [3:0] DEV_OP_MODE = 4'hb;
	localparam logic [3:0] DEV_MARKER = 4'hc;
	localparam logic [3:0] DEV_SCALE = 4'hd;

	// device field positions
	localparam int CMD_START_BIT = 1;
	localparam int CMD_TABLE_BIT = 2;
	localparam int CMD_PAUSE_BIT = 3;
	localparam int MODE_THROUGH_BIT = 1;
	localparam int MODE_LIO_LOAD_BIT = 2;
	localparam int MODE_LIO_STORE_BIT = 3;
	localparam int ENTRY_SYMBOL_BIT = 15;

	// device value limits
	localparam logic [15:0] LINE_MAX = 16'hffff;
	localparam logic [15:0] LINE_NONE = 16'h0000;
	localparam logic [15:0] LINE_REF_LOAD = 16'h0002;
	localparam logic [14:0] PROB_MIN = 15'h0001;
	localparam logic [14:0] PROB_MAX = 15'h5b12;
	localparam logic [10:0] TABLE_DEPTH = 11'h400;

	////////////////////////////////////////////////////////////////////////////
	// controller registers on apb (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_LINES = 8'h04;
	localparam logic [7:0] A_MODE = 8'h08;
	localparam logic [7:0] A_SCALE = 8'h0c;
	localparam logic [7:0] A_MARKER = 8'h10;
	localparam logic [7:0] A_TABLE_WORD = 8'h14;
	localparam logic [7:0] A_RESULT = 8'h18;
	localparam logic [7:0] A_RAW = 8'h1c;
	localparam logic [7:0] A_STATUS = 8'h20;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SET_LINES = 4'h1,
		OP_REWRITE_LINES = 4'h2,
		OP_SET_MODE = 4'h3,
		OP_SET_SCALE = 4'h4,
		OP_SET_MARKER = 4'h5,
		OP_TABLE_WRITE = 4'h6,
		OP_TABLE_READ = 4'h7,
		OP_READ_LINES = 4'h8,
		OP_READ_MARKER = 4'h9,
		OP_RAW_WRITE = 4'ha,
		OP_RAW_READ = 4'hb,
		OP_END_PROC = 4'hc
	} hbc_op_type;

	typedef enum logic [3:0] {
		ERR_NONE = 4'h0,
		ERR_BUSY = 4'h1,
		ERR_ZERO_LINES = 4'h2,
		ERR_NOT_RUNNING = 4'h3,
		ERR_TABLE_CLOSED = 4'h4,
		ERR_TABLE_MIX = 4'h5,
		ERR_TABLE_VALUE = 4'h6,
		ERR_MODE = 4'h7,
		ERR_START = 4'h8,
		ERR_OPCODE = 4'h9
	} hbc_err_type;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_ISSUE = 2'b01,
		SQ_WAIT = 2'b11
	} hbc_seq_type;

	typedef enum logic [1:0] {
		BC_IDLE = 2'b00,
		BC_SETUP = 2'b01,
		BC_STROBE = 2'b11,
		BC_HOLD = 2'b10
	} hbc_bus_type;

endpackage

// ---- hdl/hbc_bus_cycle.sv ----
module hbc_bus_cycle
	import hbc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic wr,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic [7:0] rdata,
	output logic [3:0] hb_addr,
	output logic hb_cs_n,
	output logic hb_rd_n,
	output logic hb_wr_n,
	output logic [7:0] hb_data_out,
	output logic hb_data_oe_n,
	input wire logic [7:0] hb_data_in
);

	hbc_bus_type state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic [3:0] addr_r, addr_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic done_r, done_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		dout_nxt = dout_r;
		rdata_nxt = rdata_r;
		done_nxt = 1'b0;
		case (state_r)
			BC_IDLE: begin
				if (start) begin
					state_nxt = BC_SETUP;
					cnt_nxt = SETUP_CYC;
					wr_nxt = wr;
					addr_nxt = addr;
					dout_nxt = wdata;
				end
			end
			BC_SETUP: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					state_nxt = BC_STROBE;
					cnt_nxt = STROBE_CYC;
				end
			end
			BC_STROBE: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					// data is taken while the strobe is still low
					if (!wr_r)
						rdata_nxt = hb_data_in;
					state_nxt = BC_HOLD;
					cnt_nxt = HOLD_CYC;
				end
			end
			BC_HOLD: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					state_nxt = BC_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: state_nxt = BC_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= BC_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			addr_r <= 4'h0;
			dout_r <= 8'h00;
			rdata_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			dout_r <= dout_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign rdata = rdata_r;
	assign hb_addr = addr_r;
	assign hb_cs_n = (state_r == BC_IDLE);
	assign hb_rd_n = !((state_r == BC_STROBE) && !wr_r);
	assign hb_wr_n = !((state_r == BC_STROBE) && wr_r);
	assign hb_data_out = dout_r;
	// drive the data lines for the whole write cycle, release them for reads
	assign hb_data_oe_n = !((state_r != BC_IDLE) && wr_r);

endmodule

// ---- hdl/hbc_host_ctrl.sv ----
// Register access over APB was left to the implementer.
module hbc_host_ctrl
	import hbc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] hb_addr,
	output logic hb_cs_n,
	output logic hb_rd_n,
	output logic hb_wr_n,
	output logic [7:0] hb_data_out,
	output logic hb_data_oe_n,
	input wire logic [7:0] hb_data_in
);

	////////////////////////////////////////////////////////////////////////////
	// software-facing settings
	logic [15:0] lines_r, lines_nxt;
	logic [7:0] mode_r, mode_nxt;
	logic [7:0] scale_r, scale_nxt;
	logic [7:0] marker_r, marker_nxt;
	logic [15:0] tword_r, tword_nxt;
	logic [11:0] raw_r, raw_nxt;
	logic [15:0] result_r, result_nxt;
	hbc_err_type err_r, err_nxt;

	// tracking of the device's state
	logic running_r, running_nxt;
	logic start_max_r, start_max_nxt;
	logic lines_loaded_r, lines_loaded_nxt;
	logic mode_set_r, mode_set_nxt;
	logic table_open_r, table_open_nxt;
	logic table_used_r, table_used_nxt;
	logic table_store_r, table_store_nxt;
	logic [10:0] table_idx_r, table_idx_nxt;

	// byte access sequence, up to four accesses per order
	hbc_seq_type seq_r, seq_nxt;
	hbc_op_type op_r, op_nxt;
	logic [1:0] step_r, step_nxt;
	logic [1:0] last_r, last_nxt;
	logic wr_r, wr_nxt;
	logic [3:0] saddr_r [4];
	logic [3:0] saddr_nxt [4];
	logic [7:0] sdata_r [4];
	logic [7:0] sdata_nxt [4];

	logic bus_done;
	logic [7:0] bus_rdata;
	logic apb_wr;
	logic mapped;
	hbc_op_type req;
	logic lio_load;
	logic lio_store;
	logic pause_req;

	assign apb_wr = psel && penable && pwrite;
	assign req = hbc_op_type'(pwdata[3:0]);
	assign lio_load = mode_r[MODE_THROUGH_BIT] && mode_r[MODE_LIO_LOAD_BIT];
	assign lio_store = mode_r[MODE_THROUGH_BIT] && mode_r[MODE_LIO_STORE_BIT];
	assign pause_req = raw_r[CMD_PAUSE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped offsets answer with an error
	always_comb begin
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			A_CTRL: prdata = {27'h000_0000, seq_r != SQ_IDLE, err_r};
			A_LINES: prdata = {16'h0000, lines_r};
			A_MODE: prdata = {24'h00_0000, mode_r};
			A_SCALE: prdata = {24'h00_0000, scale_r};
			A_MARKER: prdata = {24'h00_0000, marker_r};
			A_TABLE_WORD: prdata = {16'h0000, tword_r};
			A_RESULT: prdata = {16'h0000, result_r};
			A_RAW: prdata = {20'h0_0000, raw_r};
			A_STATUS: prdata = {16'h0000, running_r, table_open_r, table_used_r,
				table_store_r, 1'b0, table_idx_r};
			default: mapped = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	////////////////////////////////////////////////////////////////////////////
	// order acceptance and sequencing
	always_comb begin
		lines_nxt = lines_r;
		mode_nxt = mode_r;
		scale_nxt = scale_r;
		marker_nxt = marker_r;
		tword_nxt = tword_r;
		raw_nxt = raw_r;
		result_nxt = result_r;
		err_nxt = err_r;
		running_nxt = running_r;
		start_max_nxt = start_max_r;
		lines_loaded_nxt = lines_loaded_r;
		mode_set_nxt = mode_set_r;
		table_open_nxt = table_open_r;
		table_used_nxt = table_used_r;
		table_store_nxt = table_store_r;
		table_idx_nxt = table_idx_r;
		seq_nxt = seq_r;
		op_nxt = op_r;
		step_nxt = step_r;
		last_nxt = last_r;
		wr_nxt = wr_r;
		saddr_nxt = saddr_r;
		sdata_nxt = sdata_r;

		if (apb_wr) begin
			case (paddr)
				A_LINES: lines_nxt = pwdata[15:0];
				A_MODE: mode_nxt = pwdata[7:0];
				A_SCALE: scale_nxt = pwdata[7:0];
				A_MARKER: marker_nxt = pwdata[7:0];
				A_TABLE_WORD: tword_nxt = pwdata[15:0];
				A_RAW: raw_nxt = pwdata[11:0];
				default: ;
			endcase
		end

		if (apb_wr && paddr == A_CTRL) begin
			if (seq_r != SQ_IDLE) begin
				err_nxt = ERR_BUSY;
			end else begin
				err_nxt = ERR_NONE;
				op_nxt = req;
				step_nxt = 2'd0;
				wr_nxt = 1'b1;
				last_nxt = 2'd0;
				seq_nxt = SQ_ISSUE;
				case (req)
					OP_SET_LINES: begin
						if (lines_r == LINE_NONE) begin
							err_nxt = ERR_ZERO_LINES;
							seq_nxt = SQ_IDLE;
						end else begin
							saddr_nxt[0] = DEV_LINE_SET_LOW;
							sdata_nxt[0] = lines_r[7:0];
							saddr_nxt[1] = DEV_LINE_SET_HIGH;
							sdata_nxt[1] = lines_r[15:8];
							last_nxt = 2'd1;
							lines_loaded_nxt = 1'b1;
						end
					end
					OP_REWRITE_LINES: begin
						if (!running_r || lines_r == LINE_NONE) begin
							err_nxt = running_r ? ERR_ZERO_LINES : ERR_NOT_RUNNING;
							seq_nxt = SQ_IDLE;
						end else if (start_max_r && !lines_loaded_r) begin
							// one free rewrite after a start with the maximum count
							saddr_nxt[0] = DEV_LINE_SET_LOW;
							sdata_nxt[0] = lines_r[7:0];
							saddr_nxt[1] = DEV_LINE_SET_HIGH;
							sdata_nxt[1] = lines_r[15:8];
							last_nxt = 2'd1;
							lines_loaded_nxt = 1'b1;
						end else begin
							// restore the maximum first so the device takes the new value
							saddr_nxt[0] = DEV_LINE_SET_LOW;
							sdata_nxt[0] = LINE_MAX[7:0];
							saddr_nxt[1] = DEV_LINE_SET_HIGH;
							sdata_nxt[1] = LINE_MAX[15:8];
							saddr_nxt[2] = DEV_LINE_SET_LOW;
							sdata_nxt[2] = lines_r[7:0];
							saddr_nxt[3] = DEV_LINE_SET_HIGH;
							sdata_nxt[3] = lines_r[15:8];
							last_nxt = 2'd3;
							lines_loaded_nxt = 1'b1;
						end
					end
					OP_SET_MODE: begin
						if (mode_r[MODE_LIO_LOAD_BIT] && mode_r[MODE_LIO_STORE_BIT]) begin
							err_nxt = ERR_MODE;
							seq_nxt = SQ_IDLE;
						end else begin
							saddr_nxt[0] = DEV_OP_MODE;
							sdata_nxt[0] = mode_r;
							mode_set_nxt = 1'b1;
						end
					end
					OP_SET_SCALE: begin
						saddr_nxt[0] = DEV_SCALE;
						sdata_nxt[0] = scale_r;
					end
					OP_SET_MARKER: begin
						saddr_nxt[0] = DEV_MARKER;
						sdata_nxt[0] = marker_r;
					end
					OP_TABLE_WRITE, OP_TABLE_READ: begin
						if (!table_open_r || table_idx_r == TABLE_DEPTH) begin
							err_nxt = ERR_TABLE_CLOSED;
							seq_nxt = SQ_IDLE;
						end else if (table_used_r && table_store_r != (req == OP_TABLE_READ)) begin
							err_nxt = ERR_TABLE_MIX;
							seq_nxt = SQ_IDLE;
						end else if (req == OP_TABLE_WRITE &&
							(tword_r[14:0] < PROB_MIN || tword_r[14:0] > PROB_MAX)) begin
							err_nxt = ERR_TABLE_VALUE;
							seq_nxt = SQ_IDLE;
						end else begin
							// low byte first, the device steps its address after each byte
							saddr_nxt[0] = DEV_TABLE_BUFFER;
							sdata_nxt[0] = tword_r[7:0];
							saddr_nxt[1] = DEV_TABLE_BUFFER;
							sdata_nxt[1] = tword_r[15:8];
							last_nxt = 2'd1;
							wr_nxt = (req == OP_TABLE_WRITE);
							table_used_nxt = 1'b1;
							table_store_nxt = (req == OP_TABLE_READ);
						end
					end
					OP_READ_LINES: begin
						saddr_nxt[0] = DEV_LINES_DONE_LOW;
						saddr_nxt[1] = DEV_LINES_DONE_HIGH;
						last_nxt = 2'd1;
						wr_nxt = 1'b0;
					end
					OP_READ_MARKER: begin
						saddr_nxt[0] = DEV_MARKER;
						wr_nxt = 1'b0;
						result_nxt = 16'h0000;
					end
					OP_RAW_WRITE: begin
						saddr_nxt[0] = raw_r[11:8];
						sdata_nxt[0] = raw_r[7:0];
						if (raw_r[11:8] == DEV_COMMAND && raw_r[CMD_START_BIT]) begin
							if (!lines_loaded_r || !mode_set_r ||
								((lio_load || lio_store) && pause_req) ||
								(lio_load && lines_r != LINE_REF_LOAD)) begin
								err_nxt = ERR_START;
								seq_nxt = SQ_IDLE;
							end else begin
								running_nxt = 1'b1;
								start_max_nxt = (lines_r == LINE_MAX);
								lines_loaded_nxt = 1'b0;
							end
						end
						if (raw_r[11:8] == DEV_COMMAND && !raw_r[CMD_START_BIT]) begin
							// opening a session restarts the device at entry zero
							if (raw_r[CMD_TABLE_BIT] && !table_open_r) begin
								table_idx_nxt = 11'h000;
								table_used_nxt = 1'b0;
							end
							table_open_nxt = raw_r[CMD_TABLE_BIT];
						end
					end
					OP_RAW_READ: begin
						saddr_nxt[0] = raw_r[11:8];
						wr_nxt = 1'b0;
						result_nxt = 16'h0000;
					end
					OP_END_PROC: begin
						running_nxt = 1'b0;
						seq_nxt = SQ_IDLE;
					end
					default: begin
						err_nxt = ERR_OPCODE;
						seq_nxt = SQ_IDLE;
					end
				endcase
			end
		end

		case (seq_r)
			SQ_IDLE: ;
			SQ_ISSUE: seq_nxt = SQ_WAIT;
			SQ_WAIT: begin
				if (bus_done) begin
					if (!wr_r) begin
						if (step_r == 2'd0)
							result_nxt[7:0] = bus_rdata;
						else
							result_nxt[15:8] = bus_rdata;
					end
					if (step_r == last_r) begin
						seq_nxt = SQ_IDLE;
						if (op_r == OP_TABLE_WRITE || op_r == OP_TABLE_READ)
							table_idx_nxt = table_idx_r + 11'h001;
					end else begin
						step_nxt = step_r + 2'd1;
						seq_nxt = SQ_ISSUE;
					end
				end
			end
			default: seq_nxt = SQ_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_r <= 16'h0000;
			mode_r <= 8'h00;
			scale_r <= 8'h00;
			marker_r <= 8'h00;
			tword_r <= 16'h0000;
			raw_r <= 12'h000;
			result_r <= 16'h0000;
			err_r <= ERR_NONE;
			running_r <= 1'b0;
			start_max_r <= 1'b0;
			lines_loaded_r <= 1'b0;
			mode_set_r <= 1'b0;
			table_open_r <= 1'b0;
			table_used_r <= 1'b0;
			table_store_r <= 1'b0;
			table_idx_r <= 11'h000;
			seq_r <= SQ_IDLE;
			op_r <= OP_NONE;
			step_r <= 2'd0;
			last_r <= 2'd0;
			wr_r <= 1'b0;
			saddr_r <= '{default: 4'h0};
			sdata_r <= '{default: 8'h00};
		end else begin
			lines_r <= lines_nxt;
			mode_r <= mode_nxt;
			scale_r <= scale_nxt;
			marker_r <= marker_nxt;
			tword_r <= tword_nxt;
			raw_r <= raw_nxt;
			result_r <= result_nxt;
			err_r <= err_nxt;
			running_r <= running_nxt;
			start_max_r <= start_max_nxt;
			lines_loaded_r <= lines_loaded_nxt;
			mode_set_r <= mode_set_nxt;
			table_open_r <= table_open_nxt;
			table_used_r <= table_used_nxt;
			table_store_r <= table_store_nxt;
			table_idx_r <= table_idx_nxt;
			seq_r <= seq_nxt;
			op_r <= op_nxt;
			step_r <= step_nxt;
			last_r <= last_nxt;
			wr_r <= wr_nxt;
			saddr_r <= saddr_nxt;
			sdata_r <= sdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one byte access on the device's host bus
	hbc_bus_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(seq_r == SQ_ISSUE),
		.wr(wr_r),
		.addr(saddr_r[step_r]),
		.wdata(sdata_r[step_r]),
		.done(bus_done),
		.rdata(bus_rdata),
		.hb_addr(hb_addr),
		.hb_cs_n(hb_cs_n),
		.hb_rd_n(hb_rd_n),
		.hb_wr_n(hb_wr_n),
		.hb_data_out(hb_data_out),
		.hb_data_oe_n(hb_data_oe_n),
		.hb_data_in(hb_data_in)
	);

endmodule

// ---- verification/hbc_host_ctrl_assertions.sv ----
module hbc_host_ctrl_chk
	import hbc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] hb_addr,
	input wire logic hb_cs_n,
	input wire logic hb_rd_n,
	input wire logic hb_wr_n,
	input wire logic [7:0] hb_data_out,
	input wire logic hb_data_oe_n,
	input wire logic [7:0] hb_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] lines_r;
	logic set_op;
	// last line count software wrote, to judge what the order must do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lines_r <= 16'h0000;
		else if (psel && penable && pwrite && paddr == A_LINES)
			lines_r <= pwdata[15:0];
	end
	assign set_op = psel && penable && pwrite && paddr == A_CTRL && pwdata[3:0] == 4'h1;
	property p_unmapped;
		psel && penable && paddr > A_STATUS |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped;
		psel && penable && paddr <= A_STATUS && paddr[1:0] == 2'b00 |-> pready && !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_zero_lines;
		set_op && lines_r == 16'h0000 |=> hb_cs_n [*8];
	endproperty
	a_zero_lines: assert property (p_zero_lines) else $error("zero line count sent");
	property p_set_lines;
		set_op && lines_r != 16'h0000 |-> ##2 !hb_cs_n && hb_addr == DEV_LINE_SET_LOW
			&& hb_data_out == lines_r[7:0];
	endproperty
	a_set_lines: assert property (p_set_lines) else $error("line count low byte not sent");
	sequence s_strobe;
		(!hb_rd_n || !hb_wr_n) [*4];
	endsequence
	property p_byte_cycle;
		$fell(hb_cs_n) |-> hb_rd_n && hb_wr_n ##1 s_strobe ##1 (hb_rd_n && hb_wr_n && !hb_cs_n)
			##1 hb_cs_n;
	endproperty
	a_byte_cycle: assert property (p_byte_cycle) else $error("bad byte cycle shape");
	property p_read_excl;
		!hb_rd_n |-> hb_wr_n && !hb_cs_n && hb_data_oe_n;
	endproperty
	a_read_excl: assert property (p_read_excl) else $error("read strobe overlaps drive");
	property p_write_hold;
		!hb_wr_n |-> !hb_cs_n && !hb_data_oe_n && $stable(hb_data_out) && $stable(hb_addr);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write data moved in strobe");
	property p_gap;
		$rose(hb_cs_n) |=> hb_cs_n;
	endproperty
	a_gap: assert property (p_gap) else $error("byte cycles too close");
	c_write: cover property ($rose(hb_wr_n));
	c_read: cover property ($rose(hb_rd_n));
	c_refused: cover property (psel && penable && pslverr);
endmodule

bind hbc_host_ctrl hbc_host_ctrl_chk u_chk (.*);

// ---- verification/hbc_dev_model.sv ----
module hbc_dev_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] hb_addr,
	input wire logic hb_cs_n,
	input wire logic hb_rd_n,
	input wire logic hb_wr_n,
	input wire logic [7:0] hb_data_out,
	output logic [7:0] hb_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [16];
	logic [7:0] tbl [2048];
	logic [7:0] found_marker_byte, last, val;
	logic [10:0] idx;
	logic [15:0] cnt;
	logic open, wr_d, rd_d;
	int nwr;
	always_comb begin
		case (hb_addr)
			4'h8: val = cnt[7:0];
			4'h9: val = cnt[15:8];
			4'ha: val = tbl[idx];
			4'hc: val = found_marker_byte;
			default: val = regs[hb_addr];
		endcase
	end
	// released bus shows a changing pattern, never the last byte
	assign hb_data_in = (!hb_cs_n && !hb_rd_n) ? val : ~last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'h00;
			{found_marker_byte, last, idx, cnt, open} <= '0;
			{wr_d, rd_d} <= 2'b11;
			nwr <= 0;
		end else begin
			wr_d <= hb_wr_n;
			rd_d <= hb_rd_n;
			last <= hb_data_in;
			if (cnt < {regs[7], regs[6]})
				cnt <= cnt + 16'h1;
			if (hb_wr_n && !wr_d) begin
				regs[hb_addr] <= hb_data_out;
				if (hb_addr == 4'h6 || hb_addr == 4'h7)
					nwr <= nwr + 1;
				if (hb_addr == 4'h2) begin
					open <= hb_data_out[2];
					idx <= 11'h0;
					if (hb_data_out[1]) begin
						cnt <= 16'h0;
						if (regs[11][1:0] == 2'b01)
							found_marker_byte <= 8'h04;
					end
				end
				if (hb_addr == 4'ha && open) begin
					tbl[idx] <= hb_data_out;
					idx <= idx + 11'h1;
				end
			end
			if (hb_rd_n && !rd_d && hb_addr == 4'ha && open)
				idx <= idx + 11'h1;
		end
	end
endmodule

// ---- verification/hbc_host_ctrl_tb_top.sv ----
module hbc_host_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import hbc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, hb_data_out, hb_data_in, m;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] hb_addr, e;
	logic hb_cs_n, hb_rd_n, hb_wr_n, hb_data_oe_n, x;
	logic [15:0] lfsr, w;
	logic [15:0] words [4];
	int miscompares, compares, n0;
	hbc_host_ctrl DUT (.*);
	hbc_dev_model u_dev (.*);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [3:0] mode_err(input logic [7:0] v);
		return (v[3:2] == 2'b11) ? 4'h7 : 4'h0;
	endfunction
	function automatic logic [3:0] tbl_err(input logic [15:0] v);
		return (v[14:0] < PROB_MIN || v[14:0] > PROB_MAX) ? 4'h6 : 4'h0;
	endfunction
	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic sw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic op(input logic [3:0] c, output logic [3:0] er);
		logic [31:0] rd;
		logic s;
		int n;
		apb(1'b1, A_CTRL, {28'h0, c}, rd, s);
		n = 0;
		do begin
			apb(1'b0, A_CTRL, 32'h0, rd, s);
			n++;
		end while (rd[4] !== 1'b0 && n < 100);
		er = rd[3:0];
		if (n >= 100) begin
			miscompares++;
			end_sim();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		lfsr = 16'd27073;
		miscompares = 0;
		compares = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_MODE, 32'h0, r, x);
		chk(r, 32'h0);
		apb(1'b0, 8'h40, 32'h0, r, x);
		chk({31'h0, x}, 32'h1);
		sw(A_LINES, 32'h0);
		op(4'h1, e);
		chk(e, 4'h2);
		sw(A_LINES, 32'h3);
		op(4'h1, e);
		chk({u_dev.regs[7], u_dev.regs[6]}, 32'h3);
		$display("line count test done");
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			m = (i < 4) ? 8'(i) : lfsr[7:0];
			if (i == 4)
				m = 8'h0e;
			sw(A_MODE, {24'h0, m});
			op(4'h3, e);
			chk(e, mode_err(m));
			if (mode_err(m) == 4'h0)
				chk(u_dev.regs[11], m);
		end
		sw(A_MODE, 32'h81);
		op(4'h3, e);
		sw(A_SCALE, {27'h0, lfsr[12:8]});
		op(4'h4, e);
		chk(u_dev.regs[13], {3'h0, lfsr[12:8]});
		sw(A_MARKER, 32'h02);
		op(4'h5, e);
		chk(u_dev.regs[12], 32'h02);
		$display("mode test done");
		sw(A_RAW, 32'h202);
		op(4'ha, e);
		op(4'h8, e);
		apb(1'b0, A_RESULT, 32'h0, r, x);
		chk(r[15:0], 32'h3);
		op(4'h9, e);
		apb(1'b0, A_RESULT, 32'h0, r, x);
		chk(r[7:0], 32'h04);
		n0 = u_dev.nwr;
		sw(A_LINES, 32'h7);
		op(4'h2, e);
		chk(u_dev.nwr - n0, 4);
		op(4'hc, e);
		sw(A_LINES, 32'hffff);
		op(4'h1, e);
		sw(A_RAW, 32'h202);
		op(4'ha, e);
		n0 = u_dev.nwr;
		sw(A_LINES, 32'h9);
		op(4'h2, e);
		chk(u_dev.nwr - n0, 2);
		chk({u_dev.regs[7], u_dev.regs[6]}, 32'h9);
		op(4'hc, e);
		op(4'h2, e);
		chk(e, 4'h3);
		sw(A_MODE, 32'h06);
		op(4'h3, e);
		sw(A_RAW, 32'h202);
		op(4'ha, e);
		chk(e, 4'h8);
		sw(A_LINES, 32'h2);
		op(4'h1, e);
		sw(A_RAW, 32'h20a);
		op(4'ha, e);
		chk(e, 4'h8);
		sw(A_RAW, 32'h202);
		op(4'ha, e);
		chk(e, 4'h0);
		op(4'hc, e);
		sw(A_RAW, 32'hb00);
		op(4'hb, e);
		apb(1'b0, A_RESULT, 32'h0, r, x);
		chk(r[15:0], 32'h06);
		// a second order while the first runs is dropped and flagged busy
		sw(A_CTRL, 32'h8);
		sw(A_CTRL, 32'h8);
		apb(1'b0, A_CTRL, 32'h0, r, x);
		chk(r[4:0], 32'h11);
		repeat (40) @(posedge pclk);
		op(4'hf, e);
		chk(e, 4'h9);
		$display("processing test done");
		sw(A_TABLE_WORD, 32'h5a1d);
		op(4'h6, e);
		chk(e, 4'h4);
		sw(A_RAW, 32'h204);
		op(4'ha, e);
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			w = {lfsr[15], 15'(lfsr[14:0] % PROB_MAX) + PROB_MIN};
			if (i == 0)
				w = 16'h5a1d;
			words[i] = w;
			sw(A_TABLE_WORD, {16'h0, w});
			op(4'h6, e);
			chk(e, tbl_err(w));
			chk({u_dev.tbl[2 * i + 1], u_dev.tbl[2 * i]}, w);
		end
		foreach (words[i]) begin
			w = i[0] ? 16'h5b13 : 16'h8000;
			sw(A_TABLE_WORD, {16'h0, w});
			op(4'h6, e);
			chk(e, tbl_err(w));
		end
		sw(A_RAW, 32'h200);
		op(4'ha, e);
		sw(A_RAW, 32'h204);
		op(4'ha, e);
		for (int i = 0; i < 4; i++) begin
			op(4'h7, e);
			apb(1'b0, A_RESULT, 32'h0, r, x);
			chk(r[15:0], words[i]);
		end
		op(4'h6, e);
		chk(e, 4'h5);
		sw(A_RAW, 32'h200);
		op(4'ha, e);
		$display("table test done");
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_MODE, 32'h0, r, x);
		chk(r, 32'h0);
		chk(u_dev.regs[11], 32'h0);
		$display("reset test done");
		end_sim();
	end
endmodule
